/* File: logic/rca_core.sv */
// rca_core: 8-bit two-stage core datapath with pin control and an AXI4-Lite register slave
// assumes: one clock mclk, synchronous inputs, program memory answering in the same cycle
// Notes on behaviour
// - separate instruction and data buses
// - whole 14-bit word fetched per cycle
// - fetch overlaps execution, two stages
// - one cycle per instruction, jumps longer
// - program store sized 512 or 1024
// - control registers sit in data space
// - any operation on any data register
// - 8-bit unit: add, sub, shift, logic
// - arithmetic in two's complement
// - two operands: accumulator plus register/constant
// - single operand: accumulator or register
// - accumulator 8 bits, not addressable
// - carry, nibble carry, zero flags updated
// - subtraction flags show inverted borrow
// - rc mode outputs quarter-rate clock
// - master clear low resets core
// - port a bit 4 open drain, timer source
// - port b software weak pull-ups
// - port b bit 0 external interrupt
// - four phases per instruction cycle
// - operand read phase two, write phase four
// - pointer change flushes fetched instruction
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "rca_map.svh"
module rca_core #(
   parameter int PROG_WORDS = 1024
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   input wire logic master_clear_n,
   output logic [12:0] prog_addr,
   input wire logic [13:0] prog_data,
   output logic [6:0] data_addr,
   output logic data_rd_en,
   input wire logic [7:0] data_rdata,
   output logic data_wr_en,
   output logic [7:0] data_wdata,
   output logic oscillator_output_clock_out,
   input wire logic [4:0] port_a_i,
   output logic [4:0] port_a_o,
   output logic [4:0] port_a_oe_n,
   input wire logic [7:0] port_b_i,
   output logic [7:0] port_b_o,
   output logic [7:0] port_b_oe_n,
   output logic [7:0] port_b_pullup_en,
   output logic main_timer_tick,
   output logic port_b_bit0_ext_irq,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int PAW = $clog2(PROG_WORDS);

   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge_bytes

   logic rst_core;
   rca_pkg::rca_phase_t phase_r;
   logic [12:0] pc_r;
   logic [13:0] fetch_r;
   logic fetch_valid_r;
   logic [13:0] ir_r;
   logic exec_valid_r;
   logic [7:0] w_r;
   logic [2:0] flags_r;
   logic [7:0] opnd_r;
   logic [7:0] result_r;
   logic [2:0] flags_nxt_r;
   logic [4:0] port_a_r;
   logic [7:0] port_b_r;
   logic [3:0] ctrl_r;
   logic [4:0] tris_a_r;
   logic [7:0] tris_b_r;
   logic pa4_prev_r;
   logic pb0_prev_r;
   logic [5:0] op;
   logic dest_f;
   logic is_lit;
   logic is_jump;
   logic ext_addr;
   rca_pkg::rca_alu_op_t alu_op;
   logic [7:0] alu_a;
   logic [7:0] alu_b;
   logic [7:0] alu_res;
   logic [2:0] alu_flags;
   logic [2:0] flag_mask;
   logic [8:0] sum9;
   logic [8:0] dif9;
   logic [4:0] nsum5;
   logic [4:0] ndif5;
   logic [7:0] rd_int;
   logic pcl_write;

   assign rst_core = reset | ~master_clear_n;

   // instruction cycle of four phases
   always_ff @(posedge mclk) begin
      if (rst_core) begin
         phase_r <= rca_pkg::RCA_PH1;
      end else if (ce) begin
         case (phase_r)
            rca_pkg::RCA_PH1: phase_r <= rca_pkg::RCA_PH2;
            rca_pkg::RCA_PH2: phase_r <= rca_pkg::RCA_PH3;
            rca_pkg::RCA_PH3: phase_r <= rca_pkg::RCA_PH4;
            rca_pkg::RCA_PH4: phase_r <= rca_pkg::RCA_PH1;
            default: phase_r <= rca_pkg::RCA_PH1;
         endcase
      end
   end

   // decode of the executing word
   assign op = ir_r[13:8];
   assign dest_f = ir_r[7];
   assign is_lit = (op[5:4] == 2'h3);
   assign is_jump = exec_valid_r && (ir_r[13:11] == `RCA_OP_GOTO);
   assign data_addr = ir_r[6:0];
   assign ext_addr = !(data_addr == `RCA_DA_PCL || data_addr == `RCA_DA_STATUS ||
                       data_addr == `RCA_DA_PORT_A_A || data_addr == `RCA_DA_PORT_B_B);

   always_comb begin
      case (op)
         `RCA_OP_MOVWF: alu_op = dest_f ? rca_pkg::RCA_ALU_PASSW : rca_pkg::RCA_ALU_NONE;
         `RCA_OP_CLR: alu_op = rca_pkg::RCA_ALU_CLR;
         `RCA_OP_SUB, `RCA_OP_SUBLW: alu_op = rca_pkg::RCA_ALU_SUB;
         `RCA_OP_OR: alu_op = rca_pkg::RCA_ALU_OR;
         `RCA_OP_AND, `RCA_OP_ANDLW: alu_op = rca_pkg::RCA_ALU_AND;
         `RCA_OP_XOR: alu_op = rca_pkg::RCA_ALU_XOR;
         `RCA_OP_ADD, `RCA_OP_ADDLW: alu_op = rca_pkg::RCA_ALU_ADD;
         `RCA_OP_MOVF: alu_op = rca_pkg::RCA_ALU_PASSF;
         `RCA_OP_RR: alu_op = rca_pkg::RCA_ALU_RR;
         `RCA_OP_RL: alu_op = rca_pkg::RCA_ALU_RL;
         `RCA_OP_MOVLW: alu_op = rca_pkg::RCA_ALU_PASSK;
         default: alu_op = rca_pkg::RCA_ALU_NONE;
      endcase
   end

   // operand b is a data register or the literal, a is the accumulator
   assign alu_a = w_r;
   assign alu_b = is_lit ? ir_r[7:0] : opnd_r;
   assign sum9 = {1'b0, alu_b} + {1'b0, alu_a};
   assign dif9 = {1'b0, alu_b} - {1'b0, alu_a};
   assign nsum5 = {1'b0, alu_b[3:0]} + {1'b0, alu_a[3:0]};
   assign ndif5 = {1'b0, alu_b[3:0]} - {1'b0, alu_a[3:0]};

   always_comb begin
      alu_res = 8'h00;
      alu_flags = flags_r;
      flag_mask = 3'h4;
      case (alu_op)
         rca_pkg::RCA_ALU_ADD: begin
            alu_res = sum9[7:0];
            alu_flags[`RCA_ST_C] = sum9[8];
            alu_flags[`RCA_ST_DC] = nsum5[4];
            flag_mask = 3'h7;
         end
         rca_pkg::RCA_ALU_SUB: begin
            alu_res = dif9[7:0];
            alu_flags[`RCA_ST_C] = ~dif9[8];
            alu_flags[`RCA_ST_DC] = ~ndif5[4];
            flag_mask = 3'h7;
         end
         rca_pkg::RCA_ALU_AND: alu_res = alu_a & alu_b;
         rca_pkg::RCA_ALU_OR: alu_res = alu_a | alu_b;
         rca_pkg::RCA_ALU_XOR: alu_res = alu_a ^ alu_b;
         rca_pkg::RCA_ALU_RL: begin
            alu_res = {alu_b[6:0], flags_r[`RCA_ST_C]};
            alu_flags[`RCA_ST_C] = alu_b[7];
            flag_mask = 3'h1;
         end
         rca_pkg::RCA_ALU_RR: begin
            alu_res = {flags_r[`RCA_ST_C], alu_b[7:1]};
            alu_flags[`RCA_ST_C] = alu_b[0];
            flag_mask = 3'h1;
         end
         rca_pkg::RCA_ALU_PASSF: alu_res = alu_b;
         rca_pkg::RCA_ALU_PASSW: begin
            alu_res = alu_a;
            flag_mask = 3'h0;
         end
         rca_pkg::RCA_ALU_PASSK: begin
            alu_res = alu_b;
            flag_mask = 3'h0;
         end
         rca_pkg::RCA_ALU_CLR: alu_res = 8'h00;
         default: flag_mask = 3'h0;
      endcase
      if (flag_mask[`RCA_ST_Z]) begin
         alu_flags[`RCA_ST_Z] = (alu_res == 8'h00);
      end
      alu_flags = (alu_flags & flag_mask) | (flags_r & ~flag_mask);
   end

   // special control registers answer inside the data space
   always_comb begin
      case (data_addr)
         `RCA_DA_PCL: rd_int = pc_r[7:0];
         `RCA_DA_STATUS: rd_int = {5'h00, flags_r};
         `RCA_DA_PORT_A_A: rd_int = {3'h0, port_a_i};
         `RCA_DA_PORT_B_B: rd_int = port_b_i;
         default: rd_int = data_rdata;
      endcase
   end

   // data bus strobes: operand read in phase two, destination write in phase four
   assign data_rd_en = ce && exec_valid_r && !is_lit && !is_jump && ext_addr &&
                       (phase_r == rca_pkg::RCA_PH2);
   assign data_wr_en = ce && exec_valid_r && !is_lit && dest_f && ext_addr &&
                       (alu_op != rca_pkg::RCA_ALU_NONE) &&
                       (phase_r == rca_pkg::RCA_PH4);
   assign data_wdata = result_r;
   assign pcl_write = exec_valid_r && !is_lit && dest_f && (data_addr == `RCA_DA_PCL) &&
                      (alu_op != rca_pkg::RCA_ALU_NONE);

   // fetch stage: whole word latched in phase four, pointer advances
   assign prog_addr = {{(13 - PAW){1'b0}}, pc_r[PAW-1:0]};
   always_ff @(posedge mclk) begin
      if (rst_core) begin
         pc_r <= 13'h0000;
         fetch_r <= 14'h0000;
         fetch_valid_r <= 1'b0;
      end else if (ce && phase_r == rca_pkg::RCA_PH4) begin
         fetch_r <= prog_data;
         if (is_jump) begin
            pc_r <= {2'h0, ir_r[10:0]};
            fetch_valid_r <= 1'b0;
         end else if (pcl_write) begin
            pc_r <= {pc_r[12:8], result_r};
            fetch_valid_r <= 1'b0;
         end else begin
            pc_r <= pc_r + 13'h0001;
            fetch_valid_r <= 1'b1;
         end
      end
   end

   // execute stage takes the fetched word in phase one
   always_ff @(posedge mclk) begin
      if (rst_core) begin
         ir_r <= 14'h0000;
         exec_valid_r <= 1'b0;
      end else if (ce && phase_r == rca_pkg::RCA_PH1) begin
         ir_r <= fetch_r;
         exec_valid_r <= fetch_valid_r;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst_core) begin
         opnd_r <= 8'h00;
         result_r <= 8'h00;
         flags_nxt_r <= 3'h0;
      end else if (ce && phase_r == rca_pkg::RCA_PH2) begin
         opnd_r <= rd_int;
      end else if (ce && phase_r == rca_pkg::RCA_PH3) begin
         result_r <= alu_res;
         flags_nxt_r <= alu_flags;
      end
   end

   // destination write: accumulator or any data register
   always_ff @(posedge mclk) begin
      if (rst_core) begin
         w_r <= 8'h00;
         flags_r <= 3'h0;
         port_a_r <= 5'h00;
         port_b_r <= 8'h00;
      end else if (ce && phase_r == rca_pkg::RCA_PH4 && exec_valid_r &&
                   alu_op != rca_pkg::RCA_ALU_NONE) begin
         if (is_lit || !dest_f) begin
            w_r <= result_r;
         end
         flags_r <= flags_nxt_r;
         if (!is_lit && dest_f) begin
            case (data_addr)
               `RCA_DA_STATUS: flags_r <= result_r[2:0];
               `RCA_DA_PORT_A_A: port_a_r <= result_r[4:0];
               `RCA_DA_PORT_B_B: port_b_r <= result_r;
               default: ;
            endcase
         end
      end
   end

   // clock out high through phases three and four
   always_ff @(posedge mclk) begin
      if (rst_core) begin
         oscillator_output_clock_out <= 1'b0;
      end else if (ce) begin
         oscillator_output_clock_out <= ctrl_r[`RCA_CTRL_RC] &&
            (phase_r == rca_pkg::RCA_PH2 || phase_r == rca_pkg::RCA_PH3);
      end
   end

   // pins
   assign port_a_o = {1'b0, port_a_r[3:0]};
   assign port_a_oe_n = {tris_a_r[4] | port_a_r[4], tris_a_r[3:0]};
   assign port_b_o = port_b_r;
   assign port_b_oe_n = tris_b_r;
   assign port_b_pullup_en = {8{ctrl_r[`RCA_CTRL_PULL]}} & tris_b_r;

   always_ff @(posedge mclk) begin
      if (rst_core) begin
         pa4_prev_r <= 1'b0;
         pb0_prev_r <= 1'b0;
         main_timer_tick <= 1'b0;
         port_b_bit0_ext_irq <= 1'b0;
      end else if (ce) begin
         pa4_prev_r <= port_a_i[4];
         pb0_prev_r <= port_b_i[0];
         main_timer_tick <= ctrl_r[`RCA_CTRL_TSRC] ? (port_a_i[4] && !pa4_prev_r) :
                            (phase_r == rca_pkg::RCA_PH4);
         port_b_bit0_ext_irq <= ctrl_r[`RCA_CTRL_IRQ] && tris_b_r[0] &&
                                port_b_i[0] && !pb0_prev_r;
      end
   end

   // AXI4-Lite slave
   logic aw_hold_r;
   logic w_hold_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic [31:0] rd_mux;
   logic rd_hit;
   logic [31:0] ctrl_merged;
   logic [31:0] tris_merged;

   assign ctrl_merged = merge_bytes({28'h0, ctrl_r}, wdata_r, wstrb_r);
   assign tris_merged = merge_bytes({16'h0, tris_b_r, 3'h0, tris_a_r}, wdata_r, wstrb_r);
   assign s_axi_awready = ce && !aw_hold_r && !s_axi_bvalid;
   assign s_axi_wready = ce && !w_hold_r && !s_axi_bvalid;
   assign s_axi_arready = ce && !s_axi_rvalid;

   always_ff @(posedge mclk) begin
      if (reset) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RCA_RESP_OKAY;
         ctrl_r <= `RCA_CTRL_RST;
         tris_a_r <= `RCA_TRIS_A_RST;
         tris_b_r <= `RCA_TRIS_B_RST;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (aw_hold_r && w_hold_r) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `RCA_RESP_OKAY;
            case ({awaddr_r[7:2], 2'h0})
               `RCA_REG_CTRL: ctrl_r <= ctrl_merged[3:0];
               `RCA_REG_TRIS: begin
                  tris_a_r <= tris_merged[4:0];
                  tris_b_r <= tris_merged[15:8];
               end
               `RCA_REG_STAT, `RCA_REG_PORT: ;
               default: s_axi_bresp <= `RCA_RESP_SLVERR;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_comb begin
      rd_hit = 1'b1;
      case ({s_axi_araddr[7:2], 2'h0})
         `RCA_REG_CTRL: rd_mux = {28'h0, ctrl_r};
         `RCA_REG_TRIS: rd_mux = {16'h0, tris_b_r, 3'h0, tris_a_r};
         `RCA_REG_STAT: rd_mux = {3'h0, pc_r, 5'h00, flags_r, w_r};
         `RCA_REG_PORT: rd_mux = {port_b_i, 3'h0, port_a_i, port_b_r, 3'h0, port_a_r};
         default: begin
            rd_mux = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RCA_RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? `RCA_RESP_OKAY : `RCA_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst_core);

   sequence s_jump_q4;
      ce && phase_r == rca_pkg::RCA_PH4 && is_jump;
   endsequence
   sequence s_flushed;
      !fetch_valid_r && pc_r == {2'h0, $past(ir_r[10:0])};
   endsequence

   a_phase_wrap: assert property (ce && phase_r == rca_pkg::RCA_PH4 |=>
      phase_r == rca_pkg::RCA_PH1) else $error("phase did not wrap after phase four");
   a_read_phase: assert property (data_rd_en |->
      phase_r == rca_pkg::RCA_PH2 && !data_wr_en) else $error("operand read off phase two");
   a_write_phase: assert property (data_wr_en |->
      phase_r == rca_pkg::RCA_PH4 && data_wdata == result_r) else $error("write off phase four");
   a_jump_flush: assert property (s_jump_q4 |=> s_flushed)
      else $error("jump did not flush fetched word");
   a_add_flags: assert property (alu_op == rca_pkg::RCA_ALU_ADD |->
      {alu_flags[`RCA_ST_C], alu_res} == alu_a + alu_b &&
      alu_flags[`RCA_ST_DC] == ((alu_a[3:0] + alu_b[3:0]) > 5'h0f))
      else $error("add result or carry wrong");
   a_sub_borrow: assert property (alu_op == rca_pkg::RCA_ALU_SUB |->
      alu_flags[`RCA_ST_C] == (alu_b >= alu_a) &&
      alu_flags[`RCA_ST_DC] == (alu_b[3:0] >= alu_a[3:0])) else $error("sub borrow wrong");
   a_zero_flag: assert property (ce && phase_r == rca_pkg::RCA_PH4 && exec_valid_r &&
      (!dest_f || is_lit) && (op == `RCA_OP_AND || op == `RCA_OP_ADD ||
      op == `RCA_OP_XOR || op == `RCA_OP_ADDLW || op == `RCA_OP_ANDLW) |=>
      flags_r[`RCA_ST_Z] == (w_r == 8'h00)) else $error("zero flag disagrees with result");
   a_clkout_rate: assert property (ce && ctrl_r[`RCA_CTRL_RC] &&
      phase_r == rca_pkg::RCA_PH2 |=> oscillator_output_clock_out)
      else $error("clock out missing in phase three");
   a_open_drain: assert property (!port_a_oe_n[4] |->
      port_a_o[4] == 1'b0 && port_a_r[4] == 1'b0) else $error("port a bit 4 drives high");
   a_pullup_input: assert property ((port_b_pullup_en & ~tris_b_r) == 8'h00)
      else $error("pull-up on an output pin");
   a_irq_edge: assert property (port_b_bit0_ext_irq |->
      $past(ctrl_r[`RCA_CTRL_IRQ]) && $past(port_b_i[0]) && !$past(pb0_prev_r))
      else $error("interrupt without rising edge");
endmodule : rca_core
`default_nettype wire

/* File: logic/rca_map.svh */
// rca_map.svh: offsets, field positions, reset values and opcodes of the core
// assumes: included by bare name from files that need the constants
`ifndef RCA_MAP_SVH
`define RCA_MAP_SVH
// bus register offsets (byte addresses)
`define RCA_REG_CTRL 8'h00
`define RCA_REG_TRIS 8'h04
`define RCA_REG_STAT 8'h08
`define RCA_REG_PORT 8'h0c
// control field positions and reset value
`define RCA_CTRL_RC 0
`define RCA_CTRL_PULL 1
`define RCA_CTRL_TSRC 2
`define RCA_CTRL_IRQ 3
`define RCA_CTRL_RST 4'h0
// direction reset: every pin an input
`define RCA_TRIS_A_RST 5'h1f
`define RCA_TRIS_B_RST 8'hff
// bus responses
`define RCA_RESP_OKAY 2'h0
`define RCA_RESP_SLVERR 2'h2
// data space locations of special control registers
`define RCA_DA_PCL 7'h02
`define RCA_DA_STATUS 7'h03
`define RCA_DA_PORT_A_A 7'h05
`define RCA_DA_PORT_B_B 7'h06
// status flag positions
`define RCA_ST_C 0
`define RCA_ST_DC 1
`define RCA_ST_Z 2
// opcodes in instruction bits 13:8, goto in bits 13:11
`define RCA_OP_MOVWF 6'h00
`define RCA_OP_CLR 6'h01
`define RCA_OP_SUB 6'h02
`define RCA_OP_OR 6'h04
`define RCA_OP_AND 6'h05
`define RCA_OP_XOR 6'h06
`define RCA_OP_ADD 6'h07
`define RCA_OP_MOVF 6'h08
`define RCA_OP_RR 6'h0c
`define RCA_OP_RL 6'h0d
`define RCA_OP_MOVLW 6'h30
`define RCA_OP_ANDLW 6'h39
`define RCA_OP_SUBLW 6'h3c
`define RCA_OP_ADDLW 6'h3e
`define RCA_OP_GOTO 3'h5
`endif

/* File: logic/rca_pkg.sv */
// rca_pkg: types of the core datapath
// assumes: nothing beyond the language
package rca_pkg;
   typedef enum logic [1:0] {
      RCA_PH1 = 2'b00,
      RCA_PH2 = 2'b01,
      RCA_PH3 = 2'b10,
      RCA_PH4 = 2'b11
   } rca_phase_t;
   typedef enum logic [3:0] {
      RCA_ALU_NONE = 4'b0000,
      RCA_ALU_ADD = 4'b0001,
      RCA_ALU_SUB = 4'b0010,
      RCA_ALU_AND = 4'b0011,
      RCA_ALU_OR = 4'b0100,
      RCA_ALU_XOR = 4'b0101,
      RCA_ALU_RL = 4'b0110,
      RCA_ALU_RR = 4'b0111,
      RCA_ALU_PASSF = 4'b1000,
      RCA_ALU_PASSW = 4'b1001,
      RCA_ALU_PASSK = 4'b1010,
      RCA_ALU_CLR = 4'b1011
   } rca_alu_op_t;
endpackage : rca_pkg

/* File: tb/rca_mem_model.sv */
// rca_mem_model: program store and data register file facing the core
// assumes: one-cycle core strobes, read data wanted in the same cycle
`timescale 1ns/1ns
`default_nettype none
module rca_mem_model (
   input wire logic mclk,
   input wire logic [12:0] prog_addr,
   output logic [13:0] prog_data,
   input wire logic [6:0] data_addr,
   input wire logic data_rd_en,
   output logic [7:0] data_rdata,
   input wire logic data_wr_en,
   input wire logic [7:0] data_wdata
);
   logic [13:0] rom [0:15];
   logic [7:0] ram [0:127];
   logic [7:0] last_r;
   // whole word every cycle on its own bus
   assign prog_data = rom[prog_addr[3:0]];
   // a released read bus shows the inverse of its last value
   assign data_rdata = data_rd_en ? ram[data_addr] : ~last_r;
   initial begin
      last_r = 8'h00;
      for (int i = 0; i < 128; i++) ram[i] = 8'haa;
   end
   always @(posedge mclk) begin
      if (data_rd_en) last_r <= ram[data_addr];
      if (data_wr_en) ram[data_addr] <= data_wdata;
   end
endmodule : rca_mem_model
`default_nettype wire

/* File: tb/risc_core_alu_datapath_bench.sv */
// risc_core_alu_datapath_bench: runs a short program, then exercises pins and registers
// assumes: rca_core and rca_mem_model compiled before this file
`timescale 1ns/1ns
`default_nettype none
`include "rca_map.svh"
module risc_core_alu_datapath_bench;
   logic mclk = 0, reset = 1, ce = 1, master_clear_n = 1;
   logic [12:0] prog_addr;
   logic [13:0] prog_data;
   logic [6:0] data_addr;
   logic data_rd_en, data_wr_en, oscillator_output_clock_out, main_timer_tick;
   logic port_b_bit0_ext_irq, clk_q = 0;
   logic [7:0] data_rdata, data_wdata, port_b_o, port_b_oe_n, port_b_pullup_en;
   logic [4:0] port_a_i = 5'h00, port_a_o, port_a_oe_n;
   logic [7:0] port_b_i = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   int err_total = 0, checks = 0, cyc = 0, n_clk = 0, n_tick = 0, n_irq = 0, a0, a1;
   always #5 mclk = ~mclk;
   rca_core #(.PROG_WORDS(1024)) dut (.*);
   rca_mem_model mem (.*);
   task automatic summarize();
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge mclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 0;
      chk(32'(s_axi_bresp), 32'(`RCA_RESP_OKAY));
   endtask : wr
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge mclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
   endtask : rd_reg
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      clk_q <= oscillator_output_clock_out;
      if (oscillator_output_clock_out && !clk_q) n_clk <= n_clk + 1;
      if (main_timer_tick) n_tick <= n_tick + 1;
      if (port_b_bit0_ext_irq) n_irq <= n_irq + 1;
      if (cyc == 4000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      for (int i = 0; i < 16; i++) mem.rom[i] = {`RCA_OP_GOTO, 11'd10};
      mem.rom[0] = {`RCA_OP_MOVLW, 8'h0f};
      mem.rom[1] = {`RCA_OP_ADDLW, 8'h01};
      mem.rom[2] = {`RCA_OP_MOVWF, 1'b1, 7'h20};
      mem.rom[3] = {`RCA_OP_SUB, 1'b1, 7'h20};
      mem.rom[4] = {`RCA_OP_SUBLW, 8'h0f};
      mem.rom[5] = {`RCA_OP_ANDLW, 8'h3c};
      mem.rom[6] = {`RCA_OP_MOVWF, 1'b1, 7'h21};
      mem.rom[7] = {`RCA_OP_RL, 1'b1, 7'h21};
      mem.rom[8] = {`RCA_OP_XOR, 1'b0, 7'h21};
      mem.rom[9] = {`RCA_OP_MOVWF, 1'b1, 7'h06};
      repeat (12) @(posedge mclk);
      reset <= 0;
      repeat (80) @(posedge mclk);
      // w = 44, z dc c = 0 1 0 at the end of the program
      rd_reg(`RCA_REG_STAT, rd, rs);
      chk({21'h0, rd[10:0]}, 32'h244);
      chk(32'(mem.ram[32]), 32'h0);
      chk(32'(mem.ram[33]), 32'h78);
      chk(32'(port_b_o), 32'h44);
      rd_reg(`RCA_REG_CTRL, rd, rs);
      chk(rd, 32'h0);
      rd_reg(`RCA_REG_TRIS, rd, rs);
      chk(rd, 32'h0000ff1f);
      rd_reg(8'h10, rd, rs);
      chk(rd, 32'h0);
      chk(32'(rs), 32'(`RCA_RESP_SLVERR));
      a0 = n_clk;
      a1 = n_tick;
      repeat (40) @(posedge mclk);
      chk(n_clk - a0, 0);
      chk(n_tick - a1, 10);
      wr(`RCA_REG_CTRL, 32'h1);
      a0 = n_clk;
      repeat (40) @(posedge mclk);
      chk(n_clk - a0, 10);
      wr(`RCA_REG_CTRL, 32'he);
      chk(32'(port_b_pullup_en), 32'hff);
      wr(`RCA_REG_TRIS, 32'h0000f10f);
      chk(32'(port_b_pullup_en), 32'hf1);
      chk({port_a_oe_n, port_a_o[4], port_b_oe_n}, {5'h0f, 1'b0, 8'hf1});
      a0 = n_tick;
      a1 = n_irq;
      repeat (3) begin
         port_a_i <= 5'h10;
         port_b_i <= 8'h01;
         repeat (3) @(posedge mclk);
         port_a_i <= 5'h00;
         port_b_i <= 8'h00;
         repeat (3) @(posedge mclk);
      end
      chk(n_tick - a0, 3);
      chk(n_irq - a1, 3);
      master_clear_n <= 0;
      repeat (8) @(posedge mclk);
      chk(32'(prog_addr), 32'h0);
      rd_reg(`RCA_REG_STAT, rd, rs);
      chk(32'(rd[7:0]), 32'h0);
      master_clear_n <= 1;
      repeat (80) @(posedge mclk);
      rd_reg(`RCA_REG_STAT, rd, rs);
      chk({21'h0, rd[10:0]}, 32'h244);
      summarize();
   end
endmodule : risc_core_alu_datapath_bench
`default_nettype wire
